//--- verilog/mf_route_pkg.sv
/*
 * Shared constants and types for the multifunction terminal router:
 * register map, field positions, reset values, terminal function codes,
 * per-terminal permission masks and the zoomed-video line map.
 * Assumes a 32-bit AXI4-Lite register bus and an 8-terminal pin bank.
 */
package mf_route_pkg;

    // Terminal count and width of one routing selector
    localparam int unsigned TERM_N = 8;
    localparam int unsigned SEL_W = 4;

    // Functions a terminal can carry; the code is the enum ordinal
    typedef enum logic [SEL_W-1:0] {
        FN_GPI,      // General-purpose input, no drive
        FN_IRQ_A,    // First parallel interrupt, open drain
        FN_IRQ_B,    // Second parallel interrupt, open drain
        FN_DMA_REQ,  // Legacy DMA request output
        FN_DMA_GNT,  // Legacy DMA grant input
        FN_RING,     // Ring-indicate output
        FN_GPE,      // General-purpose event request
        FN_ZV_STAT,  // Zoomed-video active status
        FN_CFG_SEL,  // Configuration device-select input
        FN_RSVD      // High-impedance reserved input
    } func_t;

    // Which functions each terminal may take, one bit per func_t code
    localparam logic [15:0] ALLOW_T [TERM_N] = '{
        16'h02CB, 16'h02C5, 16'h02D1, 16'h02D1,
        16'h02C9, 16'h02C1, 16'h02C1, 16'h03E9
    };

    // Register byte offsets
    localparam logic [7:0] OFF_ROUTE = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;

    // Routing reset: terminal 7 config select, 4..6 reserved, 0..3 GPI
    localparam logic [31:0] ROUTE_RESET = 32'h8999_0000;

    // Control register fields
    localparam int unsigned CTRL_SERIAL = 0;  // 1: serialized interrupts
    localparam int unsigned CTRL_PME = 1;     // 1: dedicated pin shows PME
    localparam int unsigned CTRL_ZV = 2;      // 1: zoomed-video mode
    localparam int unsigned CTRL_GNT3 = 3;    // 1: grant on terminal 3
    localparam int unsigned CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

    // Status register fields
    localparam int unsigned STAT_GPI = 0;     // Eight GPI levels
    localparam int unsigned STAT_GNT = 8;     // Grant currently seen
    localparam int unsigned STAT_CFG = 9;     // Config select seen

    // Serial interrupt slot layout
    localparam int unsigned LEGACY_IRQ_N = 16;
    localparam int unsigned SLOT_IRQ_A = LEGACY_IRQ_N;
    localparam int unsigned SLOT_IRQ_B = LEGACY_IRQ_N + 1;
    localparam int unsigned SLOT_N = LEGACY_IRQ_N + 2;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Card interface line numbers reused in zoomed-video mode
    localparam int unsigned CARD_ADDR_W = 26;
    localparam int unsigned HSYNC_LINE = 10;
    localparam int unsigned VSYNC_LINE = 11;
    localparam int unsigned LUMA_LINE [8] = '{9, 17, 8, 18, 13, 19, 14, 20};
    localparam int unsigned CHROMA_LINE [8] =
        '{21, 22, 16, 23, 15, 24, 12, 25};

    // Drive requests from the internal functions toward the terminals
    typedef struct packed {
        logic irq_a;
        logic irq_b;
        logic dma_req;
        logic ring;
        logic general_purpose_event;
        logic zv_stat;
    } fn_drive_t;

    // One terminal's driven level and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } term_pin_t;

    // Zoomed-video source from the card
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic pclk;
        logic [7:0] luma;
        logic [7:0] chroma;
    } video_t;

endpackage : mf_route_pkg

//--- verilog/term_mux.sv
/*
 * One multifunction terminal's output selector.
 * Assumes the selector is a registered routing field; purely combinational.
 */
`timescale 1ns/100ps
module term_mux
    import mf_route_pkg::*;
#(
    parameter logic [15:0] ALLOWED = 16'h02C1
) (
    input wire func_t sel,
    input wire fn_drive_t fn,
    input wire logic serial_mode,
    output term_pin_t pin
);

    // Selector is honoured only where this terminal permits it
    wire allowed = ALLOWED[sel];

    // Exactly one function owns the pin; inputs leave it undriven
    always_comb begin
        pin = '0;
        if (allowed) begin
            unique case (sel)
                // Open-drain: pull low only while asserted
                FN_IRQ_A: pin = '{out: 1'b0, oe: fn.irq_a & ~serial_mode};
                FN_IRQ_B: pin = '{out: 1'b0, oe: fn.irq_b & ~serial_mode};
                FN_DMA_REQ: pin = '{out: ~fn.dma_req, oe: 1'b1};
                FN_RING: pin = '{out: ~fn.ring, oe: 1'b1};
                FN_GPE: pin = '{out: ~fn.general_purpose_event, oe: 1'b1};
                FN_ZV_STAT: pin = '{out: fn.zv_stat, oe: 1'b1};
                // Input roles and unused codes leave the pin released
                default: pin = '0;
            endcase
        end
    end

endmodule : term_mux

//--- verilog/zv_map.sv
/*
 * Zoomed-video lane mapper onto reused card address and width lines.
 * Assumes the card's normal values arrive from the slot logic.
 */
`timescale 1ns/100ps
module zv_map
    import mf_route_pkg::*;
(
    input wire logic zv_enable,
    input wire video_t video,
    input wire logic [CARD_ADDR_W-1:0] addr_normal,
    input wire logic width16_normal,
    output logic [CARD_ADDR_W-1:0] addr_line,
    output logic width16_line
);

    // Overlay video lanes on the address bus while the mode is on
    always_comb begin
        addr_line = addr_normal;
        width16_line = width16_normal;
        if (zv_enable) begin
            addr_line[HSYNC_LINE] = video.hsync;
            addr_line[VSYNC_LINE] = video.vsync;
            width16_line = video.pclk;
            for (int i = 0; i < 8; i++) begin
                addr_line[LUMA_LINE[i]] = video.luma[i];
                addr_line[CHROMA_LINE[i]] = video.chroma[i];
            end
        end
    end

endmodule : zv_map

//--- verilog/mf_route_top.sv
/*
 * Multifunction terminal router with AXI4-Lite register access.
 * Assumes one clock, synchronous inputs, and that the host DMA logic
 * drives the grant pin and the card slot supplies its normal lines.
 */
// Operation
// R1: Terminal 0 can carry first parallel interrupt
// R2: Terminal 0 is a GPI after reset
// R3: Terminal 1 can carry second parallel interrupt
// R4: Terminal 1 is a GPI after reset
// R5: PCI interrupts may ride the serial stream
// R6: Routing register assigns secondary terminal functions
// R7: Secondary function withdraws terminal from routing
// R8: Dedicated pin shows ring or power event
// R9: Ring indicate may go to terminal 7
// R10: Host drives grant to hand over DMA
// R11: Grant accepted on terminal 2 or 3
// R12: Device asserts DMA request for transfers
// R13: DMA request on terminal 7, 4 or 0
// R14: Horizontal sync on address line 10
// R15: Vertical sync on address line 11
// R16: Pixel clock on 16-bit I/O line
// R17: Luma and chroma on reused address lines
// R18: Terminals 4 to 6 reset reserved inputs
// R19: Terminal 7 defaults to config device select
// R20: Routing is clocked and resets to default
// R21: One owner per terminal at any time
`timescale 1ns/100ps
module mf_route_top
    import mf_route_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Internal function requests
    input wire fn_drive_t fn_req,
    input wire logic [LEGACY_IRQ_N-1:0] legacy_irq,
    input wire logic pme_event,
    input wire video_t video,
    input wire logic [CARD_ADDR_W-1:0] card_addr_normal,
    input wire logic card_width16_normal,
    // Terminal bank
    input wire logic [TERM_N-1:0] multi_terminal_in,
    output logic [TERM_N-1:0] multi_terminal_out,
    output logic [TERM_N-1:0] multi_terminal_oe,
    // Function outputs
    output logic ring_indicate_out,
    output logic legacy_dma_grant,
    output logic config_device_select,
    output logic [SLOT_N-1:0] serial_irq_slots,
    output logic [CARD_ADDR_W-1:0] card_addr_line,
    output logic card_io_width16_line
);

    // Selector of terminal i out of the routing word
    function automatic func_t sel_of(input logic [31:0] r, input int i);
        sel_of = func_t'(r[i*SEL_W +: SEL_W]);
    endfunction : sel_of

    // Word-aligned register hit for a byte address
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(off));
    endfunction : hit

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            old[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
        end
        merge = old;
    endfunction : merge

    // Software state
    logic [31:0] route;           // Nibble per terminal
    logic [CTRL_W-1:0] ctrl;      // Mode bits

    // Write channel holding registers
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Mode decode
    wire serial_mode = ctrl[CTRL_SERIAL];
    wire pme_mode = ctrl[CTRL_PME];
    wire zv_enable = ctrl[CTRL_ZV];
    wire grant_on_t3 = ctrl[CTRL_GNT3];

    // Terminal selectors and input views
    func_t sel [TERM_N];
    term_pin_t next_pin [TERM_N];
    logic [TERM_N-1:0] gpi_level;

    // Each terminal gets its own selector, so no pin has two sources
    for (genvar g = 0; g < TERM_N; g++) begin : g_term
        assign sel[g] = sel_of(route, g);  // [R6] [R21]
        // Only a terminal left in GPI mode reports its level
        assign gpi_level[g] = multi_terminal_in[g] & (sel[g] == FN_GPI); // [R7]
        term_mux #(
            .ALLOWED(ALLOW_T[g])
        ) u_mux (
            .sel(sel[g]),
            .fn(fn_req),
            .serial_mode(serial_mode),
            .pin(next_pin[g])
        );
    end

    // Grant is active low on terminal 2 or 3, whichever the CTRL_GNT3 bit picks
    wire gnt_t2 = (sel[2] == FN_DMA_GNT) & ~grant_on_t3;
    wire gnt_t3 = (sel[3] == FN_DMA_GNT) & grant_on_t3;
    wire next_grant = (gnt_t2 & ~multi_terminal_in[2]) |
                      (gnt_t3 & ~multi_terminal_in[3]);  // [R11] [R10]
    wire next_cfg = (sel[7] == FN_CFG_SEL) & multi_terminal_in[7]; // [R19]
    // Dedicated pin shows either event, chosen by the mode bit
    wire next_ring = pme_mode ? pme_event : fn_req.ring;  // [R8]
    // PCI interrupts join the serial slots only in serial mode
    wire [SLOT_N-1:0] next_slots = {fn_req.irq_b & serial_mode,
                                    fn_req.irq_a & serial_mode,
                                    legacy_irq};  // [R5]

    // Zoomed-video overlay
    logic [CARD_ADDR_W-1:0] next_addr;
    logic next_width16;
    zv_map u_zv (
        .zv_enable(zv_enable),
        .video(video),
        .addr_normal(card_addr_normal),
        .width16_normal(card_width16_normal),
        .addr_line(next_addr),
        .width16_line(next_width16)
    );

    // Bus write decode
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire wr_route = hit(aw_addr, OFF_ROUTE);
    wire wr_ctrl = hit(aw_addr, OFF_CTRL);
    wire wr_status = hit(aw_addr, OFF_STATUS);
    wire wr_ok = wr_route | wr_ctrl | wr_status;
    wire [31:0] ctrl_word = {{(32-CTRL_W){1'b0}}, ctrl};
    wire [31:0] route_wr = merge(route, w_data, w_strb);
    wire [31:0] ctrl_wr = merge(ctrl_word, w_data, w_strb);

    // Bus read decode
    wire rd_take = s_axi_arvalid & s_axi_arready;
    wire rd_route = hit(s_axi_araddr, OFF_ROUTE);
    wire rd_ctrl = hit(s_axi_araddr, OFF_CTRL);
    wire rd_status = hit(s_axi_araddr, OFF_STATUS);
    wire [31:0] status_word = ({{(32-TERM_N){1'b0}}, gpi_level}
                               << STAT_GPI) |
                              (32'(legacy_dma_grant) << STAT_GNT) |
                              (32'(config_device_select) << STAT_CFG);
    wire [31:0] next_rdata = rd_route ? route :
                             rd_ctrl ? ctrl_word :
                             rd_status ? status_word : 32'h0000_0000;
    wire rd_ok = rd_route | rd_ctrl | rd_status;

    // Routing and mode registers; new routing takes hold next edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            route <= ROUTE_RESET;  // [R2] [R4] [R18] [R19] [R20]
            ctrl <= CTRL_RESET;
        end else if (do_write) begin
            if (wr_route) begin
                route <= route_wr;  // [R6] [R20]
            end
            if (wr_ctrl) begin
                ctrl <= ctrl_wr[CTRL_W-1:0];
            end
        end
    end

    // Write address and data are caught independently, in any order
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Readies are registered; each drops once its half is held
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= ~(aw_held | (s_axi_awvalid & s_axi_awready)) &
                             ~do_write & ~s_axi_bvalid;
            s_axi_wready <= ~(w_held | (s_axi_wvalid & s_axi_wready)) &
                            ~do_write & ~s_axi_bvalid;
            s_axi_arready <= ~s_axi_rvalid & ~rd_take;
        end
    end

    // Write response: status-register writes are ignored but okay
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read response; unmapped addresses read zero with an error
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Terminal and function outputs, all registered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            multi_terminal_out <= '0;
            multi_terminal_oe <= '0;  // [R2] [R4] [R18]
            ring_indicate_out <= 1'b0;
            legacy_dma_grant <= 1'b0;
            config_device_select <= 1'b0;
            serial_irq_slots <= '0;
            card_addr_line <= '0;
            card_io_width16_line <= 1'b0;
        end else begin
            for (int i = 0; i < TERM_N; i++) begin
                multi_terminal_out[i] <= next_pin[i].out;  // [R1] [R3] [R9]
                multi_terminal_oe[i] <= next_pin[i].oe;  // [R12] [R13]
            end
            ring_indicate_out <= next_ring;
            legacy_dma_grant <= next_grant;
            config_device_select <= next_cfg;
            serial_irq_slots <= next_slots;
            card_addr_line <= next_addr;  // [R14] [R15] [R17]
            card_io_width16_line <= next_width16;  // [R16]
        end
    end

    // Checks, all on the bus clock; all but the reset-value check gated by reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_route_reset_value: assert property (@(posedge clk_sys) disable iff (1'b0)
        rst |=> route == ROUTE_RESET && ctrl == CTRL_RESET) // [R20] [R2] [R19]
        else $error("routing not at default after reset");
    a_irq_a_on_t0: assert property ( // [R1]
        sel[0] == FN_IRQ_A && !serial_mode && fn_req.irq_a
        |=> multi_terminal_oe[0] && !multi_terminal_out[0])
        else $error("first interrupt not on terminal 0");
    a_irq_b_on_t1: assert property ( // [R3]
        sel[1] == FN_IRQ_B && !serial_mode && fn_req.irq_b
        |=> multi_terminal_oe[1] && !multi_terminal_out[1])
        else $error("second interrupt not on terminal 1");
    a_serial_irq_slot: assert property ( // [R5]
        serial_mode && fn_req.irq_a |=> serial_irq_slots[SLOT_IRQ_A])
        else $error("interrupt missing from serial slot");
    a_gpi_released: assert property ( // [R7]
        sel[0] == FN_GPI ##1 sel[0] == FN_GPI |-> !multi_terminal_oe[0])
        else $error("GPI terminal is driven");
    a_ring_pin_mode: assert property ( // [R8]
        !pme_mode && fn_req.ring |=> ring_indicate_out)
        else $error("ring event not on dedicated pin");
    a_dma_req_t4: assert property ( // [R13]
        sel[4] == FN_DMA_REQ && fn_req.dma_req
        |=> multi_terminal_oe[4] && !multi_terminal_out[4])
        else $error("DMA request not on terminal 4");
    a_grant_on_t3: assert property ( // [R11]
        grant_on_t3 && sel[3] == FN_DMA_GNT && !multi_terminal_in[3]
        |=> legacy_dma_grant)
        else $error("grant on terminal 3 not seen");
    a_zv_lane_map: assert property ( // [R14] [R17]
        zv_enable |=> card_addr_line[HSYNC_LINE] == $past(video.hsync)
        && card_addr_line[LUMA_LINE[7]] == $past(video.luma[7])
        && card_addr_line[CHROMA_LINE[7]] == $past(video.chroma[7]))
        else $error("video lanes misplaced");
    a_write_answer: assert property ( // [R6]
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write answer late");

    c_serial_irq: cover property (serial_mode && fn_req.irq_b);
    c_grant_seen: cover property (legacy_dma_grant);
    c_zv_mode: cover property (zv_enable && video.pclk);
    c_ring_t7: cover property (sel[7] == FN_RING && multi_terminal_oe[7]);

endmodule : mf_route_top

//--- sim/host_model.sv
/*
 * Host chipset stand-in on the terminal bank: pull-ups, wire resolution
 * and an active-low DMA grant answering an active-low request.
 * Assumes the bench picks the request and grant terminals.
 */
`timescale 1ns/100ps
module host_model
    import mf_route_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [TERM_N-1:0] pin_out,
    input wire logic [TERM_N-1:0] pin_oe,
    input wire logic [TERM_N-1:0] ext,
    input wire logic dma_on,
    input wire logic [2:0] req_t,
    input wire logic [2:0] gnt_t,
    input wire logic [3:0] delay,
    output logic [TERM_N-1:0] level
);
    logic gnt_n; // Grant wire, active low
    logic [3:0] cnt; // Cycles the request has waited
    wire logic req = dma_on && !level[req_t];

    // Grant after the set delay; withdrawn as soon as the request goes
    always_ff @(posedge clk_sys) begin
        if (rst || !req) begin
            gnt_n <= 1'b1;
            cnt <= 4'h0;
        end else if (cnt >= delay) begin
            gnt_n <= 1'b0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    // Device drive wins; an undriven wire rests at its pull-up level unless the host holds the grant low on it
    always_comb begin
        level = ext;
        for (int i = 0; i < TERM_N; i++) begin
            if (pin_oe[i]) level[i] = pin_out[i];
        end
        if (dma_on && !pin_oe[gnt_t]) level[gnt_t] = gnt_n & ext[gnt_t];
    end
endmodule : host_model

//--- sim/mf_route_top_tb.sv
/*
 * Self-checking bench for the terminal router: AXI4-Lite tasks, then
 * routing, interrupt, DMA, ring, status and video sequences.
 * Assumes host_model stands on the terminal bank.
 */
`timescale 1ns/100ps
module mf_route_top_tb
    import mf_route_pkg::*;
;
    logic clk_sys, rst, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, r;
    logic [1:0] br, rr;
    fn_drive_t fn;
    video_t vid;
    logic pme, cwl, ring, gnt, cfg, dma_on;
    logic [CARD_ADDR_W-1:0] can, cal, e;
    logic [TERM_N-1:0] tin, tout, toe, ext;
    logic [SLOT_N-1:0] slots;
    logic [2:0] rq_t, gn_t;
    logic [3:0] gdly;
    int fail_count, checks, n, rt, gt;

    mf_route_top i_dut (
        .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .fn_req(fn), .legacy_irq(16'hA5C3),
        .pme_event(pme), .video(vid), .card_addr_normal(can),
        .card_width16_normal(1'b1), .multi_terminal_in(tin),
        .multi_terminal_out(tout), .multi_terminal_oe(toe),
        .ring_indicate_out(ring), .legacy_dma_grant(gnt),
        .config_device_select(cfg), .serial_irq_slots(slots),
        .card_addr_line(cal), .card_io_width16_line(cwl)
    );

    host_model i_host (
        .clk_sys(clk_sys), .rst(rst), .pin_out(tout), .pin_oe(toe),
        .ext(ext), .dma_on(dma_on), .req_t(rq_t), .gnt_t(gn_t),
        .delay(gdly), .level(tin)
    );

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Outputs lag inputs by one cycle; the grant path adds two more
    task settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle

    task wr_reg(input logic [7:0] a, input logic [31:0] d,
                input logic [1:0] xr);
        @(posedge clk_sys);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        bry <= 1'b0;
        chk({29'h0, bv, br}, {29'h1, xr}, "write resp");
    endtask : wr_reg

    task rd_chk(input logic [7:0] a, input logic [31:0] x,
                input logic [31:0] m, input logic [1:0] xr);
        @(posedge clk_sys);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rry <= 1'b0;
        chk(rd & m, x, "read data");
        chk({29'h0, rv, rr}, {29'h1, xr}, "read resp");
    endtask : rd_chk

    task report_and_stop;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rst = 1'b1;
        {awv, wv, bry, arv, rry, pme, dma_on, awa, ara, wd} = '0;
        {fn, vid, rq_t, gn_t, gdly, fail_count, checks} = '0;
        can = 26'h155_5555;
        ext = 8'hFF;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        settle;
        chk(32'(toe), 32'h0, "reset drive");
        rd_chk(OFF_ROUTE, ROUTE_RESET, '1, RESP_OKAY);
        rd_chk(OFF_STATUS, 32'h20F, 32'h3FF, RESP_OKAY);
        rd_chk(8'h0C, 32'h0, '1, RESP_SLVERR);
        wr_reg(8'h0C, '1, RESP_SLVERR);
        @(posedge clk_sys);
        ext <= 8'h7F;
        settle;
        chk(32'(cfg), 32'h0, "cfg select");
        // Parallel interrupts are open drain: low level, enable on
        wr_reg(OFF_ROUTE, 32'h8999_0021, RESP_OKAY);
        @(posedge clk_sys);
        ext <= 8'hFF;
        fn <= 6'h30;
        settle;
        chk(32'({toe[1:0], tin[1:0]}), 32'hC, "parallel irq");
        wr_reg(OFF_CTRL, 32'h1, RESP_OKAY);
        settle;
        chk(32'(slots), 32'h3_A5C3, "serial slots");
        chk(32'(toe[1:0]), 32'h0, "serial pins");
        wr_reg(OFF_CTRL, 32'h0, RESP_OKAY);
        wr_reg(OFF_ROUTE, 32'h8999_0012, RESP_OKAY);
        settle;
        chk(32'(toe[1:0]), 32'h0, "bad code");
        // Request on 0, 4, 7; grant on 2 or 3; last pass selects wrong one
        for (int i = 0; i < 4; i++) begin
            rt = (i == 1) ? 4 : (i == 2) ? 7 : 0;
            gt = (i == 1) ? 3 : 2;
            r = ROUTE_RESET;
            r[4*rt +: 4] = 4'h3;
            r[4*gt +: 4] = 4'h4;
            wr_reg(OFF_ROUTE, r, RESP_OKAY);
            wr_reg(OFF_CTRL, (i % 2) ? 32'h8 : 32'h0, RESP_OKAY);
            @(posedge clk_sys);
            rq_t <= 3'(rt);
            gn_t <= 3'(gt);
            gdly <= 4'(3 * i);
            dma_on <= 1'b1;
            fn <= 6'h08;
            settle;
            chk(32'({toe[rt], tout[rt]}), 32'h2, "dma req");
            for (n = 0; n < 20 && gnt !== 1'b1; n++) @(posedge clk_sys);
            #1;
            chk(32'(gnt), (i == 3) ? 32'h0 : 32'h1, "grant");
            @(posedge clk_sys);
            fn <= 6'h0;
            settle;
            chk(32'(gnt), 32'h0, "grant drop");
        end
        wr_reg(OFF_ROUTE, 32'h5999_0000, RESP_OKAY);
        @(posedge clk_sys);
        dma_on <= 1'b0;
        fn <= 6'h04;
        settle;
        chk(32'({ring, toe[7], tout[7]}), 32'h6, "ring");
        wr_reg(OFF_CTRL, 32'h2, RESP_OKAY);
        @(posedge clk_sys);
        fn <= 6'h0;
        pme <= 1'b1;
        settle;
        chk(32'({ring, toe[7], tout[7]}), 32'h7, "pme");
        // Terminal 3 taken by the event output drops out of the GPI view
        // Terminal 2 shows video status, driven high against a low wire
        wr_reg(OFF_ROUTE, 32'h8999_6700, RESP_OKAY);
        @(posedge clk_sys);
        ext <= 8'hF3;
        fn <= 6'h01;
        settle;
        rd_chk(OFF_STATUS, 32'h03, 32'hFF, RESP_OKAY);
        chk(32'({toe[3:2], tin[3:2]}), 32'hF, "event pins");
        wr_reg(OFF_CTRL, 32'h4, RESP_OKAY);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys);
            vid <= p ? ~19'h5_81C3 : 19'h5_81C3;
            settle;
            e = can;
            e[HSYNC_LINE] = vid.hsync;
            e[VSYNC_LINE] = vid.vsync;
            for (int k = 0; k < 8; k++) begin
                e[LUMA_LINE[k]] = vid.luma[k];
                e[CHROMA_LINE[k]] = vid.chroma[k];
            end
            chk(32'({cal, cwl}), 32'({e, vid.pclk}), "video");
        end
        wr_reg(OFF_CTRL, 32'h0, RESP_OKAY);
        settle;
        chk(32'({cal, cwl}), 32'({can, 1'b1}), "card lines");
        // Second reset in mid-run restores the default routing
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        settle;
        rd_chk(OFF_ROUTE, ROUTE_RESET, '1, RESP_OKAY);
        rd_chk(OFF_CTRL, 32'h0, '1, RESP_OKAY);
        report_and_stop;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk_sys);
        fail_count++;
        report_and_stop;
    end
endmodule : mf_route_top_tb
